// *** common/lsmc_defines.vh ***
// Register offsets, field positions, reset values and codes of the lock status bank.
// Assumes a 15-bit register address and 8-bit register data on the serial port.
`ifndef LSMC_DEFINES_VH
`define LSMC_DEFINES_VH

// Register offsets
`define LSMC_OFF_PIN2_CFG      15'h016E
`define LSMC_OFF_L2_POWER      15'h0173
`define LSMC_OFF_L1_HOLD       15'h0177
`define LSMC_OFF_LOST_CLEAR    15'h0182
`define LSMC_OFF_LOCK_STATUS   15'h0183
`define LSMC_OFF_INPUT_RB      15'h0184
`define LSMC_OFF_DAC_LOW_RB    15'h0185

// Field positions
`define LSMC_SEL_HI            7
`define LSMC_SEL_LO            3
`define LSMC_TYPE_HI           2
`define LSMC_TYPE_LO           0
`define LSMC_PRE_PD_BIT        6
`define LSMC_L2_PD_BIT         5
`define LSMC_HOLD_BIT          5
`define LSMC_CLR_L1_BIT        1
`define LSMC_CLR_L2_BIT        0
`define LSMC_ST_L1_LOST_BIT    3
`define LSMC_ST_L1_LIVE_BIT    2
`define LSMC_ST_L2_LOST_BIT    1
`define LSMC_ST_L2_LIVE_BIT    0

// Reset values
`define LSMC_RST_SEL           5'h00
`define LSMC_RST_TYPE          3'h6
`define LSMC_RST_PRE_PD        1'h1
`define LSMC_RST_L2_PD         1'h1
`define LSMC_RST_HOLD          1'h0
`define LSMC_RST_CLR           1'h0

// Pin two source codes
`define LSMC_SRC_LOW           5'h00
`define LSMC_SRC_L1_LOCK       5'h01
`define LSMC_SRC_L2_LOCK       5'h02
`define LSMC_SRC_BOTH_LOCK     5'h03
`define LSMC_SRC_HOLDOVER      5'h04
`define LSMC_SRC_DAC_LOCKED    5'h05
`define LSMC_SRC_SERIAL_RB     5'h07
`define LSMC_SRC_DAC_RAIL      5'h08
`define LSMC_SRC_DAC_LOW       5'h09
`define LSMC_SRC_DAC_HIGH      5'h0A
`define LSMC_SRC_DIV_BASE      5'h0B
`define LSMC_SRC_DIV_LAST      5'h12

// Pin two drive types
`define LSMC_TYPE_PUSH_PULL    3'h3
`define LSMC_TYPE_INVERTED     3'h4
`define LSMC_TYPE_OPEN_DRAIN   3'h6

// Serial frame: read flag, address, data
`define LSMC_FRAME_BITS        5'h18
`define LSMC_ADDR_DONE_BITS    5'h10

`endif

// *** src/lsmc_lock_detect.v ***
// Digital lock detect: counts consecutive in-window phase detector cycles.
// Assumes pd_tick and in_window come from logic on clk.
`default_nettype none

module lsmc_lock_detect (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        enable,
    input  wire        pd_tick,
    input  wire        in_window,
    input  wire [13:0] lock_count,
    output reg         locked
);

    reg [13:0] run_count;

    // Run count, cleared by any out-of-window cycle or while disabled
    always @(posedge clk)
    begin
        if (!rst_n || !enable)
        begin
            run_count <= 14'h0000;
            locked    <= 1'b0;
        end
        else if (pd_tick)
        begin
            if (!in_window)
            begin
                run_count <= 14'h0000;
                locked    <= 1'b0;
            end
            else
            begin
                if (run_count != 14'h3FFF)
                    run_count <= run_count + 14'h0001;
                if ((run_count + 14'h0001) >= lock_count)
                    locked <= 1'b1;
            end
        end
    end

endmodule // lsmc_lock_detect

`default_nettype wire

// *** src/lsmc_serial_port.v ***
// Serial register port: 24-bit frames, read flag, 15-bit address, 8-bit data, MSB first.
// Assumes the serial clock is slow against clk (high and low phases of at least 4 clk cycles).
`include "lsmc_defines.vh"
`default_nettype none

module lsmc_serial_port (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        spi_cs_n,
    input  wire        spi_sck,
    input  wire        spi_sdi,
    input  wire [7:0]  rd_data,
    output reg  [14:0] reg_addr,
    output reg  [7:0]  wr_data,
    output reg         wr_en,
    output reg         sdo,
    output reg         sdo_oe
);

    reg [1:0]  cs_sync;
    reg [1:0]  sck_sync;
    reg [1:0]  sdi_sync;
    reg        sck_prev;
    reg [4:0]  bit_count;
    reg        read_frame;
    reg [7:0]  out_shift;
    reg [22:0] in_shift;
    wire sck_rise = sck_sync[1] & ~sck_prev;
    wire sck_fall = ~sck_sync[1] & sck_prev;
    wire [23:0] next_frame = {in_shift, sdi_sync[1]};

    // Two-stage synchronisers for the pins
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            cs_sync  <= 2'h3;
            sck_sync <= 2'h0;
            sdi_sync <= 2'h0;
            sck_prev <= 1'b0;
        end
        else
        begin
            cs_sync  <= {cs_sync[0], spi_cs_n};
            sck_sync <= {sck_sync[0], spi_sck};
            sdi_sync <= {sdi_sync[0], spi_sdi};
            sck_prev <= sck_sync[1];
        end
    end

    // Frame shifter, write strobe and read data shift-out
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            bit_count  <= 5'h00;
            read_frame <= 1'b0;
            out_shift  <= 8'h00;
            in_shift   <= 23'h000000;
            reg_addr   <= 15'h0000;
            wr_data    <= 8'h00;
            wr_en      <= 1'b0;
            sdo        <= 1'b0;
            sdo_oe     <= 1'b0;
        end
        else if (cs_sync[1])
        begin
            bit_count  <= 5'h00;
            read_frame <= 1'b0;
            wr_en      <= 1'b0;
            sdo_oe     <= 1'b0;
        end
        else
        begin
            wr_en <= 1'b0;
            if (sck_rise && bit_count != `LSMC_FRAME_BITS)
            begin
                in_shift  <= next_frame[22:0];
                bit_count <= bit_count + 5'h01;
                if (bit_count == 5'h00)
                    read_frame <= sdi_sync[1];
                if (bit_count == `LSMC_ADDR_DONE_BITS - 5'h01)
                    reg_addr <= next_frame[14:0];
                if (bit_count == `LSMC_FRAME_BITS - 5'h01)
                begin
                    wr_data <= next_frame[7:0];
                    wr_en   <= ~read_frame;
                end
            end
            // Load the read word once the address is complete
            if (bit_count == `LSMC_ADDR_DONE_BITS && read_frame && sck_fall && !sdo_oe)
            begin
                sdo       <= rd_data[7];
                out_shift <= {rd_data[6:0], 1'b0};
                sdo_oe    <= 1'b1;
            end
            else if (sdo_oe && sck_fall)
            begin
                sdo       <= out_shift[7];
                out_shift <= {out_shift[6:0], 1'b0};
            end
        end
    end

endmodule // lsmc_serial_port

`default_nettype wire

// *** src/lsmc_top.v ***
// Lock status and miscellaneous control register bank with the second status pin.
// Assumes loop, DAC and divider signals arrive from logic on clk; serial pins are asynchronous.
`include "lsmc_defines.vh"
`default_nettype none

// Overview of operation
// - Five-bit source selector in bits 7:3 picks what drives status pin two.
// - Three-bit drive type: push-pull, inverted push-pull, open drain; resets to open drain.
// - Power bit 6 powers down the second-loop prescaler; resets to 1.
// - Power bit 5 powers down the entire second loop; resets to 1.
// - Hold bit 5 keeps the first loop reference divider in reset; resets to 0.
// - While the hold bit is set, first-loop lock detect never asserts.
// - Clear bit 1 holds the first-loop lost flag at 0; write 1 then 0.
// - Clear bit 0 holds the second-loop lost flag at 0; write 1 then 0.
// - Status bit 3 sets on a falling edge of first-loop lock detect.
// - Status bit 1 sets on a falling edge of second-loop lock detect.
// - Status bit 2 reads the live first-loop lock detect level.
// - Status bit 0 reads live second-loop lock, valid when routed or forced.
// - Input readback register shows select, loss and DAC value top bits.
// - A force-enable bit runs second-loop lock detect without any pin routing.
// - Lock asserts after a programmed run of in-window cycles; a miss restarts.
module lsmc_top (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        spi_cs_n,
    input  wire        spi_sck,
    input  wire        spi_sdi,
    output wire        spi_sdo,
    output wire        spi_sdo_oe,
    input  wire [4:0]  pin1_source_select,
    input  wire        loop2_detect_force_enable,
    input  wire        loop1_pd_tick,
    input  wire        loop1_in_window,
    input  wire [13:0] loop1_lock_count,
    input  wire        loop2_pd_tick,
    input  wire        loop2_in_window,
    input  wire [13:0] loop2_lock_count,
    input  wire        holdover_active,
    input  wire        dac_locked,
    input  wire        dac_rail,
    input  wire        dac_low,
    input  wire        dac_high,
    input  wire [9:0]  dac_value_readback,
    input  wire [2:0]  input_select_readback,
    input  wire [1:0]  input_loss_readback,
    input  wire        loop1_feedback_divider_out,
    input  wire        loop2_feedback_divider_out,
    input  wire        loop1_reference_divider_out,
    input  wire        loop2_reference_divider_out,
    output reg         lock_status_pin_two,
    output reg         lock_status_pin_two_oe,
    output reg         loop2_prescaler_powerdown,
    output reg         loop2_powerdown,
    output reg         loop1_ref_divider_hold,
    output reg         loop1_lock_live,
    output reg         loop2_lock_live
);

    reg  [4:0]  pin2_source_select;
    reg  [2:0]  pin2_drive_type;
    reg         loop1_lock_lost_clear;
    reg         loop2_lock_lost_clear;
    reg         loop1_lock_lost_flag;
    reg         loop2_lock_lost_flag;
    reg  [3:0]  div_prev;
    reg  [3:0]  div_half;
    reg  [7:0]  rd_data;
    reg         next_pin2_level;
    wire [14:0] reg_addr;
    wire [7:0]  wr_data;
    wire        wr_en;
    wire        loop1_detect;
    wire        loop2_detect;
    wire [3:0]  div_out;
    wire [4:0]  div_sel;
    wire        loop2_routed;

    // Serial register port
    lsmc_serial_port u_port (
        .clk      (clk),
        .rst_n    (rst_n),
        .spi_cs_n (spi_cs_n),
        .spi_sck  (spi_sck),
        .spi_sdi  (spi_sdi),
        .rd_data  (rd_data),
        .reg_addr (reg_addr),
        .wr_data  (wr_data),
        .wr_en    (wr_en),
        .sdo      (spi_sdo),
        .sdo_oe   (spi_sdo_oe)
    );

    // Loop-two detect runs when a pin routes it or it is forced on
    assign loop2_routed = (pin1_source_select == `LSMC_SRC_L2_LOCK)
                       || (pin1_source_select == `LSMC_SRC_BOTH_LOCK)
                       || (pin2_source_select == `LSMC_SRC_L2_LOCK)
                       || (pin2_source_select == `LSMC_SRC_BOTH_LOCK)
                       || loop2_detect_force_enable;

    // Lock detectors; loop one is held off by the divider hold
    lsmc_lock_detect u_loop1_detect (
        .clk        (clk),
        .rst_n      (rst_n),
        .enable     (~loop1_ref_divider_hold),
        .pd_tick    (loop1_pd_tick),
        .in_window  (loop1_in_window),
        .lock_count (loop1_lock_count),
        .locked     (loop1_detect)
    );

    lsmc_lock_detect u_loop2_detect (
        .clk        (clk),
        .rst_n      (rst_n),
        .enable     (loop2_routed),
        .pd_tick    (loop2_pd_tick),
        .in_window  (loop2_in_window),
        .lock_count (loop2_lock_count),
        .locked     (loop2_detect)
    );

    // Control register writes; status register takes no write
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            pin2_source_select        <= `LSMC_RST_SEL;
            pin2_drive_type           <= `LSMC_RST_TYPE;
            loop2_prescaler_powerdown <= `LSMC_RST_PRE_PD;
            loop2_powerdown           <= `LSMC_RST_L2_PD;
            loop1_ref_divider_hold    <= `LSMC_RST_HOLD;
            loop1_lock_lost_clear     <= `LSMC_RST_CLR;
            loop2_lock_lost_clear     <= `LSMC_RST_CLR;
        end
        else if (wr_en)
        begin
            case (reg_addr)
                `LSMC_OFF_PIN2_CFG:
                begin
                    pin2_source_select <= wr_data[`LSMC_SEL_HI:`LSMC_SEL_LO];
                    pin2_drive_type    <= wr_data[`LSMC_TYPE_HI:`LSMC_TYPE_LO];
                end
                `LSMC_OFF_L2_POWER:
                begin
                    loop2_prescaler_powerdown <= wr_data[`LSMC_PRE_PD_BIT];
                    loop2_powerdown           <= wr_data[`LSMC_L2_PD_BIT];
                end
                `LSMC_OFF_L1_HOLD:
                    loop1_ref_divider_hold <= wr_data[`LSMC_HOLD_BIT];
                `LSMC_OFF_LOST_CLEAR:
                begin
                    loop1_lock_lost_clear <= wr_data[`LSMC_CLR_L1_BIT];
                    loop2_lock_lost_clear <= wr_data[`LSMC_CLR_L2_BIT];
                end
                default:
                    pin2_source_select <= pin2_source_select;
            endcase
        end
    end

    // Live lock levels and sticky lost flags on falling edges
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            loop1_lock_live      <= 1'b0;
            loop2_lock_live      <= 1'b0;
            loop1_lock_lost_flag <= 1'b0;
            loop2_lock_lost_flag <= 1'b0;
        end
        else
        begin
            loop1_lock_live <= loop1_detect;
            loop2_lock_live <= loop2_detect;
            if (loop1_lock_lost_clear)
                loop1_lock_lost_flag <= 1'b0;
            else if (loop1_lock_live && !loop1_detect)
                loop1_lock_lost_flag <= 1'b1;
            if (loop2_lock_lost_clear)
                loop2_lock_lost_flag <= 1'b0;
            else if (loop2_lock_live && !loop2_detect)
                loop2_lock_lost_flag <= 1'b1;
        end
    end

    // Divider outputs and their halves, one toggle per divider
    assign div_out = {loop2_reference_divider_out, loop1_reference_divider_out,
                      loop2_feedback_divider_out, loop1_feedback_divider_out};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_half
            always @(posedge clk)
            begin
                if (!rst_n)
                begin
                    div_prev[gi] <= 1'b0;
                    div_half[gi] <= 1'b0;
                end
                else
                begin
                    div_prev[gi] <= div_out[gi];
                    if (div_out[gi] && !div_prev[gi])
                        div_half[gi] <= ~div_half[gi];
                end
            end
        end
    endgenerate

    assign div_sel = pin2_source_select - `LSMC_SRC_DIV_BASE;

    // Pin two source selection
    always @*
    begin
        next_pin2_level = 1'b0;
        case (pin2_source_select)
            `LSMC_SRC_LOW:        next_pin2_level = 1'b0;
            `LSMC_SRC_L1_LOCK:    next_pin2_level = loop1_lock_live;
            `LSMC_SRC_L2_LOCK:    next_pin2_level = loop2_lock_live;
            `LSMC_SRC_BOTH_LOCK:  next_pin2_level = loop1_lock_live & loop2_lock_live;
            `LSMC_SRC_HOLDOVER:   next_pin2_level = holdover_active;
            `LSMC_SRC_DAC_LOCKED: next_pin2_level = dac_locked;
            `LSMC_SRC_SERIAL_RB:  next_pin2_level = spi_sdo;
            `LSMC_SRC_DAC_RAIL:   next_pin2_level = dac_rail;
            `LSMC_SRC_DAC_LOW:    next_pin2_level = dac_low;
            `LSMC_SRC_DAC_HIGH:   next_pin2_level = dac_high;
            default:
            begin
                if (pin2_source_select >= `LSMC_SRC_DIV_BASE && pin2_source_select <= `LSMC_SRC_DIV_LAST)
                    next_pin2_level = div_sel[0] ? div_half[div_sel[2:1]] : div_out[div_sel[2:1]];
                else
                    next_pin2_level = 1'b0;
            end
        endcase
    end

    // Pin two drive type
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            lock_status_pin_two    <= 1'b0;
            lock_status_pin_two_oe <= 1'b0;
        end
        else
        begin
            case (pin2_drive_type)
                `LSMC_TYPE_PUSH_PULL:
                begin
                    lock_status_pin_two    <= next_pin2_level;
                    lock_status_pin_two_oe <= 1'b1;
                end
                `LSMC_TYPE_INVERTED:
                begin
                    lock_status_pin_two    <= ~next_pin2_level;
                    lock_status_pin_two_oe <= 1'b1;
                end
                `LSMC_TYPE_OPEN_DRAIN:
                begin
                    lock_status_pin_two    <= 1'b0;
                    lock_status_pin_two_oe <= ~next_pin2_level;
                end
                default:
                begin
                    lock_status_pin_two    <= 1'b0;
                    lock_status_pin_two_oe <= 1'b0;
                end
            endcase
        end
    end

    // Read data, reserved bits as zero
    always @*
    begin
        rd_data = 8'h00;
        case (reg_addr)
            `LSMC_OFF_PIN2_CFG:
                rd_data = {pin2_source_select, pin2_drive_type};
            `LSMC_OFF_L2_POWER:
                rd_data = {1'b0, loop2_prescaler_powerdown, loop2_powerdown, 5'h00};
            `LSMC_OFF_L1_HOLD:
                rd_data = {2'h0, loop1_ref_divider_hold, 5'h00};
            `LSMC_OFF_LOST_CLEAR:
                rd_data = {6'h00, loop1_lock_lost_clear, loop2_lock_lost_clear};
            `LSMC_OFF_LOCK_STATUS:
                rd_data = {4'h0, loop1_lock_lost_flag, loop1_lock_live,
                           loop2_lock_lost_flag, loop2_lock_live};
            `LSMC_OFF_INPUT_RB:
                rd_data = {dac_value_readback[9:8], input_select_readback, 1'b0, input_loss_readback};
            `LSMC_OFF_DAC_LOW_RB:
                rd_data = dac_value_readback[7:0];
            default:
                rd_data = 8'h00;
        endcase
    end

endmodule // lsmc_top

`default_nettype wire

// *** tb/lsmc_monitor.sv ***
// Port-level checks of the lock status register bank.
// Assumes one clock domain with synchronous active-low reset; bound to lsmc_top below.
`default_nettype none

module lsmc_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic spi_cs_n,
    input wire logic spi_sdo_oe,
    input wire logic loop1_pd_tick,
    input wire logic loop1_in_window,
    input wire logic loop2_pd_tick,
    input wire logic loop2_in_window,
    input wire logic loop1_lock_live,
    input wire logic loop2_lock_live,
    input wire logic loop1_ref_divider_hold,
    input wire logic loop2_prescaler_powerdown,
    input wire logic loop2_powerdown,
    input wire logic lock_status_pin_two,
    input wire logic lock_status_pin_two_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Detector misses and the state left by reset
    sequence s_miss1; loop1_pd_tick && !loop1_in_window; endsequence
    sequence s_miss2; loop2_pd_tick && !loop2_in_window; endsequence
    sequence s_reset_state;
        loop2_prescaler_powerdown && loop2_powerdown && !loop1_ref_divider_hold && !spi_sdo_oe;
    endsequence
    sequence s_pin_idle; lock_status_pin_two_oe && !lock_status_pin_two; endsequence
    // Lock detect, power and pin relations
    property p_hold_no_lock; loop1_ref_divider_hold [*3] |-> !loop1_lock_live; endproperty
    a_hold_no_lock: assert property (p_hold_no_lock) else $error("loop one locked while held");
    property p_l1_miss; s_miss1 |-> ##2 !loop1_lock_live; endproperty
    a_l1_miss: assert property (p_l1_miss) else $error("loop one lock kept after a miss");
    property p_l2_miss; s_miss2 |-> ##2 !loop2_lock_live; endproperty
    a_l2_miss: assert property (p_l2_miss) else $error("loop two lock kept after a miss");
    property p_l1_rise;
        $rose(loop1_lock_live) |-> $past(loop1_pd_tick, 2) && $past(loop1_in_window, 2);
    endproperty
    a_l1_rise: assert property (p_l1_rise) else $error("loop one lock without a hit");
    property p_l2_rise;
        $rose(loop2_lock_live) |-> $past(loop2_pd_tick, 2) && $past(loop2_in_window, 2);
    endproperty
    a_l2_rise: assert property (p_l2_rise) else $error("loop two lock without a hit");
    property p_reset; $rose(rst_n) |-> s_reset_state ##3 s_pin_idle; endproperty
    a_reset: assert property (p_reset) else $error("wrong state after reset");
    property p_cfg_quiet;
        spi_cs_n [*8] |=> $stable(loop2_prescaler_powerdown) && $stable(loop2_powerdown)
            && $stable(loop1_ref_divider_hold);
    endproperty
    a_cfg_quiet: assert property (p_cfg_quiet) else $error("control bit moved without a frame");
    property p_sdo_release; spi_cs_n [*5] |-> !spi_sdo_oe; endproperty
    a_sdo_release: assert property (p_sdo_release) else $error("read data driven outside a frame");
    property p_pin_hi; lock_status_pin_two |-> lock_status_pin_two_oe; endproperty
    a_pin_hi: assert property (p_pin_hi) else $error("pin two high but undriven");
endmodule // lsmc_monitor

bind lsmc_top lsmc_monitor lsmc_monitor_inst (.clk(clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n),
    .spi_sdo_oe(spi_sdo_oe), .loop1_pd_tick(loop1_pd_tick), .loop1_in_window(loop1_in_window),
    .loop2_pd_tick(loop2_pd_tick), .loop2_in_window(loop2_in_window), .loop1_lock_live(loop1_lock_live),
    .loop2_lock_live(loop2_lock_live), .loop1_ref_divider_hold(loop1_ref_divider_hold),
    .loop2_prescaler_powerdown(loop2_prescaler_powerdown), .loop2_powerdown(loop2_powerdown),
    .lock_status_pin_two(lock_status_pin_two), .lock_status_pin_two_oe(lock_status_pin_two_oe));

`default_nettype wire

// *** tb/lsmc_host_model.sv ***
// Serial host: 24-bit frames of read flag, address and data, MSB first.
// Assumes clk from the bench; pins change after clk falls, sck idles low.
`default_nettype none

module lsmc_host_model (
    input  wire logic clk,
    input  wire logic spi_sdo,
    output var  logic spi_cs_n,
    output var  logic spi_sck,
    output var  logic spi_sdi
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle pins
    initial
    begin
        spi_cs_n = 1'b1;
        spi_sck = 1'b0;
        spi_sdi = 1'b0;
    end

    // One frame; sck phases of 5 clk, read bits taken before each late rise
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] q);
        logic [23:0] f;
        f = {rd, a, wd};
        q = 8'h00;
        @(negedge clk);
        spi_cs_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 23; i >= 0; i--)
        begin
            spi_sdi = f[i];
            repeat (5) @(negedge clk);
            if (i < 8)
                q[i] = spi_sdo;
            spi_sck = 1'b1;
            repeat (5) @(negedge clk);
            spi_sck = 1'b0;
        end
        repeat (8) @(negedge clk);
        spi_cs_n = 1'b1;
        spi_sdi = ~spi_sdi; // No stale data between frames
        repeat (8) @(negedge clk);
    endtask
endmodule // lsmc_host_model

`default_nettype wire

// *** tb/test_lsmc_top.sv ***
// Bench for the lock status bank: register traffic, lock detect, lost flags, pin two.
// Assumes the host model for frames; other inputs change after clk falls.
`default_nettype none

module test_lsmc_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cs_n, sck, sdi, sdo, sdo_oe, pin2, pin2_oe, pre_pd, l2_pd, hold, live1, live2;
    logic        force_en = 1'b0;
    logic        src = 1'b0;
    logic [1:0]  tk = 2'b00;
    logic [1:0]  wn = 2'b00;
    logic [4:0]  p1_sel = 5'h00;
    logic [14:0] rb = {10'h2A5, 3'h5, 2'h2};
    int          bad_count = 0;
    int          tests_run = 0;

    // Clock
    always #2 clk = ~clk;

    lsmc_host_model lsmc_host_model_inst (.clk(clk), .spi_sdo(sdo), .spi_cs_n(cs_n), .spi_sck(sck), .spi_sdi(sdi));

    lsmc_top lsmc_top_inst (.clk(clk), .rst_n(rst_n), .spi_cs_n(cs_n), .spi_sck(sck), .spi_sdi(sdi),
        .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .pin1_source_select(p1_sel), .loop2_detect_force_enable(force_en),
        .loop1_pd_tick(tk[0]), .loop1_in_window(wn[0]), .loop1_lock_count(14'h0003),
        .loop2_pd_tick(tk[1]), .loop2_in_window(wn[1]), .loop2_lock_count(14'h0003),
        .holdover_active(src), .dac_locked(src), .dac_rail(src), .dac_low(src), .dac_high(src),
        .dac_value_readback(rb[14:5]), .input_select_readback(rb[4:2]), .input_loss_readback(rb[1:0]),
        .loop1_feedback_divider_out(src), .loop2_feedback_divider_out(src),
        .loop1_reference_divider_out(src), .loop2_reference_divider_out(src),
        .lock_status_pin_two(pin2), .lock_status_pin_two_oe(pin2_oe), .loop2_prescaler_powerdown(pre_pd),
        .loop2_powerdown(l2_pd), .loop1_ref_divider_hold(hold), .loop1_lock_live(live1), .loop2_lock_live(live2));

    // Comparison, verdict and register access
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want)
        begin
            bad_count++;
            $display("mismatch at %0t: seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic final_report;
        if (bad_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        lsmc_host_model_inst.xfer(1'b0, a, d, q);
    endtask
    task automatic rd(input logic [14:0] a, input logic [7:0] want);
        logic [7:0] q;
        lsmc_host_model_inst.xfer(1'b1, a, 8'h00, q);
        check(q, want);
    endtask
    // Phase detector ticks, each a one-cycle pulse with a gap
    task automatic ticks(input logic [1:0] which, input logic win, input int n);
        repeat (n)
        begin
            @(negedge clk);
            tk = which;
            wn = {win, win};
            @(negedge clk);
            tk = 2'b00;
        end
        repeat (3) @(negedge clk);
    endtask

    // Power-on values at pins and registers
    task automatic t_defaults;
        check({pre_pd, l2_pd, hold}, 3'h6);
        check({pin2, pin2_oe}, 2'b01);
        rd(15'h016E, 8'h06);
        rd(15'h0173, 8'h60);
        rd(15'h0177, 8'h00);
        rd(15'h0182, 8'h00);
        rd(15'h0183, 8'h00);
    endtask

    // Control bits, reserved bits, read-only and unmapped places
    task automatic t_regs;
        wr(15'h0173, 8'hFF);
        rd(15'h0173, 8'h60);
        wr(15'h0173, 8'h20);
        check({pre_pd, l2_pd}, 2'b01);
        wr(15'h0173, 8'h40);
        check({pre_pd, l2_pd}, 2'b10);
        wr(15'h0177, 8'hFF);
        check(hold, 1'b1);
        rd(15'h0177, 8'h20);
        ticks(2'b01, 1'b1, 5);
        check(live1, 1'b0);
        wr(15'h0177, 8'h00);
        check(hold, 1'b0);
        wr(15'h0183, 8'hFF);
        rd(15'h0183, 8'h00);
        wr(15'h0100, 8'h5A);
        rd(15'h0100, 8'h00);
        rd(15'h0184, 8'hAA);
        rd(15'h0185, 8'hA5);
    endtask

    // Loop one: threshold, live readback, sticky loss and its clear
    task automatic t_lock1;
        ticks(2'b01, 1'b0, 1);
        ticks(2'b01, 1'b1, 2);
        check(live1, 1'b0);
        ticks(2'b01, 1'b1, 1);
        check(live1, 1'b1);
        rd(15'h0183, 8'h04);
        ticks(2'b01, 1'b0, 1);
        rd(15'h0183, 8'h08);
        wr(15'h0182, 8'h02);
        rd(15'h0183, 8'h00);
        ticks(2'b01, 1'b1, 3);
        ticks(2'b01, 1'b0, 1);
        rd(15'h0183, 8'h00);
        wr(15'h0182, 8'h00);
        rd(15'h0183, 8'h00);
    endtask

    // Loop two: detector enable, live readback, sticky loss and its clear
    task automatic t_lock2;
        ticks(2'b10, 1'b1, 4);
        check(live2, 1'b0);
        force_en = 1'b1;
        ticks(2'b10, 1'b1, 3);
        check(live2, 1'b1);
        rd(15'h0183, 8'h01);
        {force_en, p1_sel} = {1'b0, 5'h02};
        ticks(2'b10, 1'b0, 1);
        rd(15'h0183, 8'h02);
        wr(15'h0182, 8'h01);
        rd(15'h0183, 8'h00);
        wr(15'h0182, 8'h00);
        rd(15'h0183, 8'h00);
        p1_sel = 5'h00;
    endtask

    // Pin two drive types and source codes
    task automatic t_pin2;
        int codes[17] = '{0, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 31};
        ticks(2'b01, 1'b1, 3);
        wr(15'h016E, 8'h0B);
        check({pin2, pin2_oe}, 2'b11);
        wr(15'h016E, 8'h0C);
        check({pin2, pin2_oe}, 2'b01);
        wr(15'h016E, 8'h0E);
        check({pin2, pin2_oe}, 2'b00);
        rd(15'h016E, 8'h0E);
        for (int s = 0; s < 2; s++)
            foreach (codes[k])
            begin
                src = s[0];
                wr(15'h016E, {codes[k][4:0], 3'h3});
                check(pin2, s[0] && !(codes[k] inside {0, 6, 7}) && codes[k] < 19);
            end
        wr(15'h016E, 8'h06);
    endtask

    // Main sequence
    initial
    begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_defaults;
        t_regs;
        t_lock1;
        t_lock2;
        t_pin2;
        final_report;
    end

    // Run limit
    initial
    begin
        repeat (100000) @(posedge clk);
        bad_count++;
        final_report;
    end
endmodule // test_lsmc_top

`default_nettype wire
